/* src/fsp_defines.vh */
// Constants for the flash segment program and erase sequencer
`ifndef FSP_DEFINES_VH
`define FSP_DEFINES_VH

// =====================================================================
// Address map
`define FSP_MAIN_BASE 16'hf800
`define FSP_MAIN_LAST 16'hffff
`define FSP_VEC_BASE 16'hffc0
`define FSP_INFO_BASE 16'h1000
`define FSP_INFO_LAST 16'h10ff
`define FSP_INFO_PAGE 8'h10
`define FSP_SEGA_BASE 16'h10c0
`define FSP_CAL_BASE 16'h10f8

// =====================================================================
// Array geometry, as linear byte index: main first, then information
`define FSP_MAIN_BYTES 12'h800
`define FSP_INFO_BYTES 12'h100
`define FSP_MAIN_SEG_BYTES 12'h200
`define FSP_INFO_SEG_BYTES 12'h040
`define FSP_MAIN_LAST_IDX 12'h7ff
`define FSP_ALL_LAST_IDX 12'h8ff
`define FSP_SEGA_IDX_HI 6'h23
`define FSP_ERASED 8'hff

// =====================================================================
// Commands
`define FSP_CMD_PROG 2'h0
`define FSP_CMD_SEG_ERASE 2'h1
`define FSP_CMD_MAIN_ERASE 2'h2
`define FSP_CMD_ALL_ERASE 2'h3

// =====================================================================
// Sequencer states, one-hot
`define FSP_ST_IDLE 4'h1
`define FSP_ST_PROG 4'h2
`define FSP_ST_ERASE 4'h4
`define FSP_ST_DONE 4'h8

// =====================================================================
// Reset values
`define FSP_LOCK_A_RST 1'b1

`endif

/* src/fsp_sync3.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fsp_sync3 #(
    parameter WIDTH = 1
) (
    input wire ref_clk,
    input wire reset_n,
    input wire clk_en,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    // First stage feeds only the second stage
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change is accepted only once two settled stages agree
            if (s2_q == s3_q) begin
                sync_out <= s3_q;
            end
        end
    end
endmodule // fsp_sync3

/* src/fsp_flash_ctrl.v */
// Flash array with segment program and erase sequencer
//
// Contract
// - Main segments are 512 aligned bytes
// - Four 64-byte information segments A to D
// - Main erase: all segments or one
// - Info segment alone, or all with main, segment A kept while locked
// - Segment A locked after every reset
// - Program one byte or one word
// - Requests from core and debug port
// - Main decodes 0F800h-0FFFFh, vectors at top
// - Information decodes 01000h-010FFh
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_flash_ctrl (
    input wire ref_clk,
    input wire reset_n,
    input wire clk_en,
    input wire cpu_req,
    input wire [1:0] cpu_cmd,
    input wire [15:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    input wire cpu_word,
    input wire dbg_req,
    input wire [1:0] dbg_cmd,
    input wire [15:0] dbg_addr,
    input wire [15:0] dbg_wdata,
    input wire dbg_word,
    input wire unlock_a,
    input wire lock_a,
    input wire [15:0] rd_addr,
    output reg [15:0] rd_data_q,
    output reg busy_q,
    output reg done_q,
    output reg viol_q,
    output reg lock_a_q
);
    // =================================================================
    // Storage
    reg [7:0] main_mem [0:2047];
    reg [7:0] info_mem [0:255];

    reg [3:0] state_q;
    reg [11:0] idx_q;
    reg [11:0] last_q;
    reg [15:0] data_q;
    reg word_q;
    reg dbg_req_q;

    wire dbg_req_s;
    wire [1:0] dbg_cmd_s;
    wire [15:0] dbg_addr_s;
    wire [15:0] dbg_wdata_s;
    wire dbg_word_s;

    // =================================================================
    // Debug port pins arrive from outside the clock domain
    fsp_sync3 #(
        .WIDTH(36)
    ) u_dbg_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in({dbg_req, dbg_cmd, dbg_addr, dbg_wdata, dbg_word}),
        .sync_out({dbg_req_s, dbg_cmd_s, dbg_addr_s, dbg_wdata_s, dbg_word_s})
    );

    // =================================================================
    // Address decode into one linear index: main 0..7FFh, info 800h..8FFh
    function [12:0] map_addr;
        input [15:0] a;
        begin
            if (a >= `FSP_MAIN_BASE) begin
                map_addr = {1'b1, 1'b0, a[10:0]};
            end else if (a[15:8] == `FSP_INFO_PAGE) begin
                map_addr = {1'b1, 4'h8, a[7:0]};
            end else begin
                map_addr = 13'h0000;
            end
        end
    endfunction

    function is_seg_a;
        input [11:0] i;
        begin
            is_seg_a = (i[11:6] == `FSP_SEGA_IDX_HI);
        end
    endfunction

    function [7:0] rd_byte;
        input [11:0] i;
        begin
            if (i[11]) begin
                rd_byte = info_mem[i[7:0]];
            end else begin
                rd_byte = main_mem[i[10:0]];
            end
        end
    endfunction

    // =================================================================
    // Request selection; debug port wins a tie since it halts the core
    wire dbg_start = dbg_req_s & ~dbg_req_q;
    wire start = dbg_start | cpu_req;
    wire [1:0] sel_cmd = dbg_start ? dbg_cmd_s : cpu_cmd;
    wire [15:0] sel_addr = dbg_start ? dbg_addr_s : cpu_addr;
    wire [15:0] sel_data = dbg_start ? dbg_wdata_s : cpu_wdata;
    wire sel_word = dbg_start ? dbg_word_s : cpu_word;
    wire [12:0] sel_map = map_addr(sel_addr);
    wire sel_ok = sel_map[12];
    wire [11:0] sel_idx = sel_map[11:0];
    wire [12:0] rd_map = map_addr(rd_addr);
    wire [11:0] rd_idx = rd_map[11:0] & 12'hffe;
    wire rd_ok = rd_map[12];
    wire erase_skip = lock_a_q & is_seg_a(idx_q);

    // =================================================================
    // Sequencer
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= `FSP_ST_IDLE;
            idx_q <= 12'h000;
            last_q <= 12'h000;
            data_q <= 16'h0000;
            word_q <= 1'b0;
            dbg_req_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            viol_q <= 1'b0;
            lock_a_q <= `FSP_LOCK_A_RST;
            rd_data_q <= 16'h0000;
        end else if (clk_en) begin
            dbg_req_q <= dbg_req_s;
            done_q <= 1'b0;
            viol_q <= 1'b0;
            if (lock_a) begin
                lock_a_q <= 1'b1;
            end else if (unlock_a) begin
                lock_a_q <= 1'b0;
            end
            // Word read; unmapped addresses read as zero
            if (rd_ok) begin
                rd_data_q <= {rd_byte(rd_idx | 12'h001), rd_byte(rd_idx)};
            end else begin
                rd_data_q <= 16'h0000;
            end
            case (state_q)
                `FSP_ST_IDLE: begin
                    if (start) begin
                        data_q <= sel_data;
                        word_q <= sel_word;
                        case (sel_cmd)
                            `FSP_CMD_PROG: begin
                                if (!sel_ok || (lock_a_q && is_seg_a(sel_idx))) begin
                                    viol_q <= 1'b1;
                                end else begin
                                    // Word writes are forced to an even address
                                    idx_q <= sel_word ? (sel_idx & 12'hffe) : sel_idx;
                                    state_q <= `FSP_ST_PROG;
                                    busy_q <= 1'b1;
                                end
                            end
                            `FSP_CMD_SEG_ERASE: begin
                                if (!sel_ok || (lock_a_q && is_seg_a(sel_idx))) begin
                                    viol_q <= 1'b1;
                                end else if (sel_idx[11]) begin
                                    idx_q <= {sel_idx[11:6], 6'h00};
                                    last_q <= {sel_idx[11:6], 6'h3f};
                                    state_q <= `FSP_ST_ERASE;
                                    busy_q <= 1'b1;
                                end else begin
                                    idx_q <= {sel_idx[11:9], 9'h000};
                                    last_q <= {sel_idx[11:9], 9'h1ff};
                                    state_q <= `FSP_ST_ERASE;
                                    busy_q <= 1'b1;
                                end
                            end
                            `FSP_CMD_MAIN_ERASE: begin
                                idx_q <= 12'h000;
                                last_q <= `FSP_MAIN_LAST_IDX;
                                state_q <= `FSP_ST_ERASE;
                                busy_q <= 1'b1;
                            end
                            default: begin
                                idx_q <= 12'h000;
                                last_q <= `FSP_ALL_LAST_IDX;
                                state_q <= `FSP_ST_ERASE;
                                busy_q <= 1'b1;
                            end
                        endcase
                    end
                end
                `FSP_ST_PROG: begin
                    state_q <= `FSP_ST_DONE;
                end
                `FSP_ST_ERASE: begin
                    // One byte per cycle keeps the array single-ported
                    if (idx_q == last_q) begin
                        state_q <= `FSP_ST_DONE;
                    end else begin
                        idx_q <= idx_q + 12'h001;
                    end
                end
                `FSP_ST_DONE: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    state_q <= `FSP_ST_IDLE;
                end
                default: begin
                    state_q <= `FSP_ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // =================================================================
    // Array writes; programming can only clear bits, as in real flash
    always @(posedge ref_clk) begin
        if (clk_en) begin
            if (state_q == `FSP_ST_PROG) begin
                if (idx_q[11]) begin
                    info_mem[idx_q[7:0]] <= info_mem[idx_q[7:0]] & data_q[7:0];
                    if (word_q) begin
                        info_mem[idx_q[7:0] | 8'h01] <=
                            info_mem[idx_q[7:0] | 8'h01] & data_q[15:8];
                    end
                end else begin
                    main_mem[idx_q[10:0]] <= main_mem[idx_q[10:0]] & data_q[7:0];
                    if (word_q) begin
                        main_mem[idx_q[10:0] | 11'h001] <=
                            main_mem[idx_q[10:0] | 11'h001] & data_q[15:8];
                    end
                end
            end
            if (state_q == `FSP_ST_ERASE && !erase_skip) begin
                if (idx_q[11]) begin
                    info_mem[idx_q[7:0]] <= `FSP_ERASED;
                end else begin
                    main_mem[idx_q[10:0]] <= `FSP_ERASED;
                end
            end
        end
    end
endmodule // fsp_flash_ctrl

/* sim/fsp_flash_ctrl_monitor.sv */
// Port assertions for the flash sequencer
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_flash_ctrl_monitor (
    input wire ref_clk,
    input wire reset_n,
    input wire clk_en,
    input wire cpu_req,
    input wire [1:0] cpu_cmd,
    input wire [15:0] cpu_addr,
    input wire [15:0] cpu_wdata,
    input wire cpu_word,
    input wire dbg_req,
    input wire [1:0] dbg_cmd,
    input wire [15:0] dbg_addr,
    input wire [15:0] dbg_wdata,
    input wire dbg_word,
    input wire unlock_a,
    input wire lock_a,
    input wire [15:0] rd_addr,
    input wire [15:0] rd_data_q,
    input wire busy_q,
    input wire done_q,
    input wire viol_q,
    input wire lock_a_q
);
    // =========================================================
    // Helper logic
    wire idle = !busy_q && !done_q && !viol_q && clk_en;
    wire in_a = cpu_addr >= `FSP_SEGA_BASE && cpu_addr <= `FSP_INFO_LAST;
    wire in_info = cpu_addr >= `FSP_INFO_BASE && cpu_addr <= `FSP_INFO_LAST;
    wire cpu_ok = cpu_addr >= `FSP_MAIN_BASE || (in_info && !(in_a && lock_a_q));
    wire [1:0] cmd = cpu_req ? cpu_cmd : dbg_cmd;
    wire [15:0] adr = cpu_req ? cpu_addr : dbg_addr;
    reg [11:0] cnt_q;
    reg [11:0] exp_q;
    // Busy length is erased bytes plus one; a program counts as one byte
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 12'h000;
            exp_q <= 12'h002;
        end else begin
            cnt_q <= busy_q ? cnt_q + 12'h001 : 12'h000;
            if (idle && (cpu_req || dbg_req))
                exp_q <= cmd == `FSP_CMD_PROG ? 12'h002 : cmd == `FSP_CMD_MAIN_ERASE ? 12'h801 :
                    cmd == `FSP_CMD_ALL_ERASE ? 12'h901 : adr >= `FSP_MAIN_BASE ? 12'h201 : 12'h041;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take;
        idle && cpu_req && !dbg_req && !unlock_a && !lock_a;
    endsequence
    sequence s_walk;
        busy_q ##1 busy_q ##1 (done_q && !busy_q);
    endsequence
    a_lock_after_reset: assert property ($past(reset_n) == 1'b0 |-> lock_a_q)
        else $error("segment A not locked after reset");
    a_prog_walk: assert property (s_take ##0 (cpu_cmd == `FSP_CMD_PROG && cpu_ok) |=> s_walk)
        else $error("program walk broken");
    a_locked_refused: assert property (s_take ##0 (in_a && lock_a_q && cpu_cmd <= 2'h1)
        |=> viol_q && !busy_q)
        else $error("locked segment request not refused");
    a_erase_length: assert property (done_q |-> cnt_q == exp_q)
        else $error("operation length wrong");
    a_done_pulse: assert property (done_q |-> !busy_q ##1 !done_q)
        else $error("done not a single pulse");
    a_lock_set: assert property (lock_a && clk_en |=> lock_a_q)
        else $error("lock request ignored");
    a_unlock_clear: assert property (unlock_a && !lock_a && clk_en |=> !lock_a_q)
        else $error("unlock request ignored");
    a_rd_unmapped: assert property (clk_en && (rd_addr < `FSP_INFO_BASE ||
        (rd_addr > `FSP_INFO_LAST && rd_addr < `FSP_MAIN_BASE)) |=> rd_data_q == 16'h0000)
        else $error("unmapped read not zero");
endmodule // fsp_flash_ctrl_monitor

bind fsp_flash_ctrl fsp_flash_ctrl_monitor i_fsp_flash_ctrl_monitor (.ref_clk, .reset_n,
    .clk_en, .cpu_req, .cpu_cmd, .cpu_addr, .cpu_wdata, .cpu_word, .dbg_req, .dbg_cmd, .dbg_addr,
    .dbg_wdata, .dbg_word, .unlock_a, .lock_a, .rd_addr, .rd_data_q, .busy_q, .done_q, .viol_q,
    .lock_a_q);

/* sim/fsp_host_model.sv */
// Debug programming port model driving the sequencer's debug pins
`timescale 1ns/1ps
module fsp_host_model (
    input wire ref_clk,
    input wire done_q,
    output reg dbg_req,
    output reg [1:0] dbg_cmd,
    output reg [15:0] dbg_addr,
    output reg [15:0] dbg_wdata,
    output reg dbg_word
);
    initial {dbg_req, dbg_cmd, dbg_addr, dbg_wdata, dbg_word} = 36'h0;
    // Fields settle well ahead of the request so the synchroniser never sees a torn word
    task automatic dbg_op(input [1:0] c, input [15:0] a, input [15:0] d, input w,
        output reg ok);
        integer k;
        @(negedge ref_clk);
        {dbg_cmd, dbg_addr, dbg_wdata, dbg_word} = {c, a, d, w};
        repeat (5) @(negedge ref_clk);
        dbg_req = 1'b1;
        for (k = 0; k < 3000 && !done_q; k = k + 1)
            @(negedge ref_clk);
        // A request that never completes is reported back to the bench
        ok = done_q;
        dbg_req = 1'b0;
        // Released address and data pins stop showing the last value
        {dbg_addr, dbg_wdata} = {~a, ~d};
    endtask
endmodule // fsp_host_model

/* sim/fsp_flash_ctrl_tb.sv */
// Self-checking testbench for the flash sequencer
`timescale 1ns/1ps
`include "fsp_defines.vh"
module fsp_flash_ctrl_tb;
    reg ref_clk, reset_n, cpu_req, cpu_word, unlock_a, lock_a, v;
    reg clk_en = 1'b1;
    reg [1:0] cpu_cmd;
    reg [15:0] cpu_addr, cpu_wdata, rd_addr;
    wire [15:0] rd_data_q, dbg_addr, dbg_wdata;
    wire [1:0] dbg_cmd;
    wire busy_q, done_q, viol_q, lock_a_q, dbg_req, dbg_word;
    integer n_fail = 0, checks = 0, cyc = 0;
    fsp_flash_ctrl i_fsp_flash_ctrl (.ref_clk, .reset_n, .clk_en, .cpu_req, .cpu_cmd,
        .cpu_addr, .cpu_wdata, .cpu_word, .dbg_req, .dbg_cmd, .dbg_addr, .dbg_wdata, .dbg_word,
        .unlock_a, .lock_a, .rd_addr, .rd_data_q, .busy_q, .done_q, .viol_q, .lock_a_q);
    fsp_host_model i_fsp_host_model (.ref_clk, .done_q, .dbg_req, .dbg_cmd, .dbg_addr,
        .dbg_wdata, .dbg_word);
    // =========================================================
    // Shared tasks
    task chk(input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task op(input [1:0] c, input [15:0] a, input [15:0] d, input w);
        integer k;
        @(negedge ref_clk);
        {cpu_cmd, cpu_addr, cpu_wdata, cpu_word, cpu_req} = {c, a, d, w, 1'b1};
        @(negedge ref_clk);
        cpu_req = 1'b0;
        for (k = 0; k < 3000 && !(done_q | viol_q); k = k + 1)
            @(negedge ref_clk);
        // A request that is never answered counts as a mismatch
        chk({15'h0000, done_q | viol_q}, 16'h0001);
        v = viol_q;
        @(negedge ref_clk);
    endtask
    task rd(input [15:0] a, input [15:0] exp);
        @(negedge ref_clk);
        rd_addr = a;
        @(negedge ref_clk);
        chk(rd_data_q, exp);
    endtask
    task lk(input [1:0] p);
        @(negedge ref_clk);
        {lock_a, unlock_a} = p;
        @(negedge ref_clk);
        {lock_a, unlock_a} = 2'b00;
    endtask
    task report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // =========================================================
    // Scenarios
    task t_main;
        op(`FSP_CMD_MAIN_ERASE, 16'hf800, 16'h0000, 1'b0);
        rd(16'hf800, 16'hffff);
        rd(16'hfffe, 16'hffff);
        op(`FSP_CMD_PROG, 16'hfffe, 16'h1234, 1'b1);
        rd(16'hfffe, 16'h1234);
        op(`FSP_CMD_PROG, 16'hf801, 16'h000f, 1'b0);
        rd(16'hf800, 16'h0fff);
    endtask
    task t_seg;
        op(`FSP_CMD_PROG, 16'hf9fe, 16'h0000, 1'b1);
        op(`FSP_CMD_PROG, 16'hfa00, 16'h0000, 1'b1);
        op(`FSP_CMD_SEG_ERASE, 16'hfa10, 16'h0000, 1'b0);
        rd(16'hfa00, 16'hffff);
        rd(16'hf9fe, 16'h0000);
    endtask
    task t_info;
        lk(2'b01);
        op(`FSP_CMD_ALL_ERASE, 16'h1000, 16'h0000, 1'b0);
        rd(16'h10fe, 16'hffff);
        op(`FSP_CMD_PROG, 16'h103e, 16'h0000, 1'b1);
        op(`FSP_CMD_PROG, 16'h1040, 16'h0000, 1'b1);
        op(`FSP_CMD_PROG, 16'h10fe, 16'h0000, 1'b1);
        op(`FSP_CMD_SEG_ERASE, 16'h1040, 16'h0000, 1'b0);
        rd(16'h1040, 16'hffff);
        rd(16'h103e, 16'h0000);
        lk(2'b10);
        op(`FSP_CMD_PROG, 16'h10c0, 16'h0000, 1'b1);
        chk({15'h0000, v}, 16'h0001);
        rd(16'h10c0, 16'hffff);
        op(`FSP_CMD_SEG_ERASE, 16'h10f8, 16'h0000, 1'b0);
        chk({15'h0000, v}, 16'h0001);
        op(`FSP_CMD_ALL_ERASE, 16'h1000, 16'h0000, 1'b0);
        rd(16'h10fe, 16'h0000);
        rd(16'h1000, 16'hffff);
        rd(16'hf800, 16'hffff);
    endtask
    task t_dbg_map;
        i_fsp_host_model.dbg_op(`FSP_CMD_PROG, 16'hf810, 16'ha5a5, 1'b1, v);
        chk({15'h0000, v}, 16'h0001);
        rd(16'hf810, 16'ha5a5);
        op(`FSP_CMD_PROG, 16'h2000, 16'h0000, 1'b1);
        chk({15'h0000, v}, 16'h0001);
        rd(16'h2000, 16'h0000);
        rd(16'h0ffe, 16'h0000);
    endtask
    // Frozen while idle only, so no pulse output is held across the freeze
    task t_freeze;
        @(negedge ref_clk);
        {clk_en, cpu_cmd, cpu_addr, cpu_wdata, cpu_word, cpu_req} =
            {1'b0, `FSP_CMD_PROG, 16'hf820, 16'h0000, 1'b1, 1'b1};
        @(negedge ref_clk);
        cpu_req = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({15'h0000, busy_q}, 16'h0000);
        clk_en = 1'b1;
        rd(16'hf820, 16'hffff);
    endtask
    task t_rst;
        lk(2'b01);
        chk({15'h0000, lock_a_q}, 16'h0000);
        reset_n = 1'b0;
        @(negedge ref_clk);
        reset_n = 1'b1;
        chk({12'h000, busy_q, done_q, viol_q, lock_a_q}, 16'h0001);
    endtask
    // =========================================================
    // Clock, run and timeout
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
    initial begin
        {reset_n, cpu_req, cpu_word, unlock_a, lock_a, cpu_cmd} = 7'h00;
        {cpu_addr, cpu_wdata, rd_addr} = 48'h0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        chk({12'h000, busy_q, done_q, viol_q, lock_a_q}, 16'h0001);
        t_main;
        t_seg;
        t_info;
        t_dbg_map;
        t_freeze;
        t_rst;
        report_and_stop;
    end
endmodule // fsp_flash_ctrl_tb
